/* File: core/mss_pkg.sv */
// Shared constants and types of the multi-speed select block
package mss_pkg;
  // ==========================================================
  // Sizes
  localparam int FREQ_W = 16;
  localparam int IDX_W  = 4;
  localparam int SLOTS  = 16;
  localparam int NTERM  = 5;
  localparam int CODE_W = 8;
  localparam int SYNC_STAGES = 2;
  // ==========================================================
  // Terminal function codes and source setting
  localparam logic [CODE_W-1:0] FC_SEL_BIT0 = 8'h02;
  localparam logic [CODE_W-1:0] SRC_MULTI   = 8'h02;
  // ==========================================================
  // Byte offsets on the register bus
  localparam logic [11:0] OFS_CTRL      = 12'h000;
  localparam logic [11:0] OFS_KEYPAD    = 12'h004;
  localparam logic [11:0] OFS_LIMIT     = 12'h008;
  localparam logic [11:0] OFS_SRC       = 12'h00C;
  localparam logic [11:0] OFS_PARAM     = 12'h010;
  localparam logic [11:0] OFS_STATUS    = 12'h014;
  localparam logic [11:0] OFS_MONITOR   = 12'h018;
  localparam logic [11:0] OFS_TERM_FUNCTION_VIEW_KEY = 12'h01C;
  localparam logic [11:0] OFS_SLOT      = 12'h040;
  localparam logic [11:0] OFS_STEP      = 12'h004;
  // ==========================================================
  // Field positions
  localparam int CTRL_STORE_SEL = 0;
  localparam int CTRL_STORE_DIR = 1;
  localparam int CTRL_UP        = 2;
  localparam int CTRL_DOWN      = 3;
  localparam int STAT_RUN       = 0;
  localparam int STAT_IDX_LSB   = 4;
  // ==========================================================
  // Values after reset
  localparam logic [FREQ_W-1:0] RST_LIMIT  = 16'h01F4;
  localparam logic [FREQ_W-1:0] RST_FREQ   = 16'h0000;
  localparam logic [CODE_W-1:0] RST_SRC    = 8'h02;
  localparam logic [NTERM-1:0][CODE_W-1:0] RST_FUNCTION_VIEW_KEY =
    {8'h05, 8'h04, 8'h03, 8'h02, 8'h01};
  // ==========================================================
  // Bus constants and states
  localparam logic [2:0] HSIZE_WORD = 3'h2;
  typedef enum logic [1:0] {
    MSS_BUS_IDLE  = 2'b00,
    MSS_BUS_WRITE = 2'b01,
    MSS_BUS_READ  = 2'b10
  } mss_bus_st_t;
endpackage

/* File: core/mss_sel_if.sv */
// Carrier between synchroniser, index decoder and core
`timescale 1ns/100ps
interface mss_sel_if import mss_pkg::*; ();
  logic [NTERM-1:0]             term;
  logic                         run;
  logic [NTERM-1:0][CODE_W-1:0] function_view_key;
  logic [IDX_W-1:0]             index;
  modport sync_mp (output term, output run);
  modport dec_mp  (input term, input function_view_key, output index);
  modport core_mp (input run, input index, output function_view_key);
endinterface

/* File: core/mss_sync.sv */
// Two-flop synchroniser for terminal and run pins
`timescale 1ns/100ps
module mss_sync import mss_pkg::*; #(
  parameter int STAGES = SYNC_STAGES
) (
  // Clock and reset
  input  wire logic             sys_clk,
  input  wire logic             rst,
  // Pins
  input  wire logic [NTERM-1:0] term_in,
  input  wire logic             run_cmd,
  // Synchronised side
  mss_sel_if.sync_mp            sel
);
  if (STAGES < 2) begin : g_chk
    $error("mss_sync needs at least two stages");
  end

  typedef struct packed {
    logic [STAGES-1:0][NTERM:0] pipe;
  } mss_sync_t;

  mss_sync_t s;
  mss_sync_t next_s;

  // ==========================================================
  // Shift; only the last stage is read outside
  always_comb begin
    next_s = s;
    next_s.pipe = {s.pipe[STAGES-2:0], {run_cmd, term_in}};
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  assign sel.term = s.pipe[STAGES-1][NTERM-1:0];
  assign sel.run  = s.pipe[STAGES-1][NTERM];
endmodule

/* File: core/mss_index_dec.sv */
// Forms the speed index from terminal states and their functions
`timescale 1ns/100ps
module mss_index_dec import mss_pkg::*; #(
  parameter int NBITS = IDX_W
) (
  // Terminal side
  mss_sel_if.dec_mp sel
);
  if (NBITS < 1 || NBITS > IDX_W) begin : g_chk
    $error("mss_index_dec index width out of range");
  end

  // ==========================================================
  // Each index bit is the OR of terminals carrying its code
  always_comb begin
    sel.index = '0;
    for (int b = 0; b < NBITS; b++) begin
      for (int t = 0; t < NTERM; t++) begin
        if (sel.function_view_key[t] == FC_SEL_BIT0 + CODE_W'(b) && sel.term[t]) begin // RULE_01 RULE_02 RULE_03 RULE_04
          sel.index[b] = 1'b1;
        end
      end
    end
    // Unassigned bits stay 0 from the default above RULE_17
  end
endmodule

/* File: core/mss_top.sv */
// Multi-speed select: speed bank, index, keypad editing, AHB-Lite slave
// What this block does
// RULE_01 - Terminal code 02 gives index bit 0
// RULE_02 - Terminal code 03 gives index bit 1
// RULE_03 - Terminal code 04 gives index bit 2
// RULE_04 - Terminal code 05 gives index bit 3
// RULE_05 - Sixteen individually writable speed slots
// RULE_06 - Slot changes only on a store press
// RULE_07 - Speeds above maximum limit cannot take effect
// RULE_08 - Monitor reports present output frequency
// RULE_09 - Operator reads monitor, not keypad, while running
// RULE_10 - Operator stops drive before terminal programming
// RULE_11 - Stopped: keypad shows terminal-selected slot
// RULE_12 - Store while stopped writes selected slot
// RULE_13 - Slots editable directly by parameter number
// RULE_14 - Up to sixteen target frequencies by index
// RULE_15 - Index zero selects the first slot
// RULE_16 - Fewer inputs assigned from bit 0 upward
// RULE_17 - Unassigned index bits read as zero
// RULE_18 - Target follows index one cycle after sync
`timescale 1ns/100ps
module mss_top import mss_pkg::*; #(
  parameter logic [FREQ_W-1:0] LIMIT_RESET = RST_LIMIT
) (
  // Clock and reset
  input  wire logic              sys_clk,
  input  wire logic              rst,
  // AHB-Lite slave
  input  wire logic              hsel,
  input  wire logic [31:0]       haddr,
  input  wire logic [1:0]        htrans,
  input  wire logic              hwrite,
  input  wire logic [2:0]        hsize,
  input  wire logic              hready,
  input  wire logic [31:0]       hwdata,
  output logic      [31:0]       hrdata,
  output logic                   hreadyout,
  output logic                   hresp,
  // Drive pins
  input  wire logic [NTERM-1:0]  term_in,
  input  wire logic              run_cmd,
  // Results
  output logic      [FREQ_W-1:0] output_freq_monitor,
  output logic      [FREQ_W-1:0] target_freq,
  output logic      [IDX_W-1:0]  speed_index
);
  if (LIMIT_RESET == '0) begin : g_chk
    $error("mss_top maximum limit must not reset to zero");
  end

  // ==========================================================
  // Sizes and map the logic can serve
  if (SLOTS != (1 << IDX_W)) begin : g_chk_slots
    $error("mss_top slot count must match the index width");
  end
  if (FREQ_W > 32 || CODE_W > 32) begin : g_chk_width
    $error("mss_top register fields must fit one bus word");
  end
  if (NTERM < IDX_W) begin : g_chk_term
    $error("mss_top needs a terminal for every index bit");
  end
  if (OFS_TERM_FUNCTION_VIEW_KEY + 4 * NTERM > OFS_SLOT) begin : g_chk_map
    $error("mss_top terminal functions overlap the slot bank");
  end
  if (OFS_SLOT + 4 * SLOTS > 4096) begin : g_chk_span
    $error("mss_top slot bank leaves the decoded window");
  end
  if (STAT_IDX_LSB + IDX_W > 32) begin : g_chk_stat
    $error("mss_top status index field must fit one bus word");
  end

  typedef struct packed {
    mss_bus_st_t                   st;
    logic [11:0]                   addr;
    logic                          hit;
    logic [31:0]                   rdata;
    logic                          ready;
    logic                          resp;
    logic [FREQ_W-1:0]             keypad_freq_setting;
    logic [FREQ_W-1:0]             max_freq_limit;
    logic [CODE_W-1:0]             freq_source_select;
    logic [IDX_W-1:0]              param_sel;
    logic [NTERM-1:0][CODE_W-1:0]  term_function_view_key;
    logic [SLOTS-1:0][FREQ_W-1:0]  slot;
    logic [IDX_W-1:0]              idx;
    logic                          run_q;
    logic [FREQ_W-1:0]             target;
    logic [FREQ_W-1:0]             monitor;
  } mss_state_t;

  mss_state_t s;
  mss_state_t next_s;

  mss_sel_if sel ();

  logic              take_xfer;
  logic              wr_now;
  logic              store_sel;
  logic              store_dir;
  logic              key_up;
  logic              key_down;
  logic [FREQ_W-1:0] src_freq;
  logic [FREQ_W-1:0] lim_freq;

  // ==========================================================
  // Pin synchroniser and index decoder
  mss_sync #(
    .STAGES (SYNC_STAGES)
  ) u_sync (
    .sys_clk (sys_clk),
    .rst     (rst),
    .term_in (term_in),
    .run_cmd (run_cmd),
    .sel     (sel.sync_mp)
  );

  mss_index_dec #(
    .NBITS (IDX_W)
  ) u_dec (
    .sel (sel.dec_mp)
  );

  assign sel.function_view_key = s.term_function_view_key;

  // ==========================================================
  // Read multiplexer
  function automatic logic [31:0] read_mux(
    input mss_state_t st
  );
    logic [31:0] d;
    d = '0;
    if (st.hit) begin
      case (st.addr)
        OFS_CTRL: begin
          // Command pulses leave nothing to read back
          d = '0;
        end
        OFS_KEYPAD: begin
          d[FREQ_W-1:0] = st.keypad_freq_setting;
        end
        OFS_LIMIT: begin
          d[FREQ_W-1:0] = st.max_freq_limit;
        end
        OFS_SRC: begin
          d[CODE_W-1:0] = st.freq_source_select;
        end
        OFS_PARAM: begin
          d[IDX_W-1:0] = st.param_sel;
        end
        OFS_STATUS: begin
          d[STAT_RUN] = sel.run;
          d[STAT_IDX_LSB +: IDX_W] = st.idx;
        end
        OFS_MONITOR: begin
          d[FREQ_W-1:0] = st.monitor; // RULE_08
        end
        default: begin
          for (int i = 0; i < NTERM; i++) begin
            if (st.addr == OFS_TERM_FUNCTION_VIEW_KEY + 12'(i * 4)) begin
              d[CODE_W-1:0] = st.term_function_view_key[i];
            end
          end
          for (int i = 0; i < SLOTS; i++) begin
            if (st.addr == OFS_SLOT + 12'(i * 4)) begin
              d[FREQ_W-1:0] = st.slot[i];
            end
          end
        end
      endcase
    end
    return d;
  endfunction

  // ==========================================================
  // Frequency source and clamp
  always_comb begin
    if (s.freq_source_select == SRC_MULTI) begin
      src_freq = s.slot[sel.index]; // RULE_14 RULE_15
    end else begin
      src_freq = s.keypad_freq_setting;
    end
    // A slot above the limit runs at the limit RULE_07
    if (src_freq > s.max_freq_limit) begin
      lim_freq = s.max_freq_limit;
    end else begin
      lim_freq = src_freq;
    end
  end

  // ==========================================================
  // Command pulses decoded from a write data phase
  always_comb begin
    take_xfer = hsel && hready && htrans[1];
    wr_now    = (s.st == MSS_BUS_WRITE) && s.hit;
    store_sel = 1'b0;
    store_dir = 1'b0;
    key_up    = 1'b0;
    key_down  = 1'b0;
    if (wr_now && s.addr == OFS_CTRL) begin
      store_sel = hwdata[CTRL_STORE_SEL];
      store_dir = hwdata[CTRL_STORE_DIR];
      key_up    = hwdata[CTRL_UP];
      key_down  = hwdata[CTRL_DOWN];
    end
  end

  // ==========================================================
  // Next state
  always_comb begin
    next_s = s;
    next_s.resp = 1'b0;

    // Data phase of a pending transfer
    case (s.st)
      MSS_BUS_READ: begin
        // One wait cycle so a read just after a write sees it
        next_s.rdata = read_mux(s);
        next_s.ready = 1'b1;
        next_s.st    = MSS_BUS_IDLE;
      end
      MSS_BUS_WRITE: begin
        next_s.st = MSS_BUS_IDLE;
      end
      MSS_BUS_IDLE: begin
        next_s.st = MSS_BUS_IDLE;
      end
      default: begin
        // Unused code falls back to idle and releases the bus
        next_s.st    = MSS_BUS_IDLE;
        next_s.ready = 1'b1;
      end
    endcase

    // Address phase
    // A new address may arrive during a write data phase
    if (take_xfer) begin
      next_s.addr = haddr[11:0];
      next_s.hit  = (haddr[31:12] == 20'h00000) && (hsize == HSIZE_WORD);
      if (hwrite) begin
        next_s.st    = MSS_BUS_WRITE;
        next_s.ready = 1'b1;
      end else begin
        next_s.st    = MSS_BUS_READ;
        next_s.ready = 1'b0;
      end
    end

    // Index tracking and keypad view while stopped
    next_s.idx   = sel.index;
    next_s.run_q = sel.run;
    // Entering stop also shows the selected slot, even with the same index
    if (!sel.run && (sel.index != s.idx || s.run_q)) begin
      next_s.keypad_freq_setting = s.slot[sel.index]; // RULE_11
    end

    // Keypad up/down editing, held inside 0..limit
    // Up wins when both keys are pressed below the limit; at the limit down applies
    if (key_up && s.keypad_freq_setting < s.max_freq_limit) begin
      next_s.keypad_freq_setting = s.keypad_freq_setting + 16'h0001;
    end else if (key_down && s.keypad_freq_setting != '0) begin
      next_s.keypad_freq_setting = s.keypad_freq_setting - 16'h0001;
    end

    // Register writes
    if (wr_now) begin
      case (s.addr)
        OFS_CTRL, OFS_STATUS, OFS_MONITOR: begin
          // Command pulses and read-only words store nothing
        end
        OFS_KEYPAD: begin
          next_s.keypad_freq_setting = hwdata[FREQ_W-1:0];
        end
        OFS_LIMIT: begin
          next_s.max_freq_limit = hwdata[FREQ_W-1:0];
        end
        OFS_SRC: begin
          next_s.freq_source_select = hwdata[CODE_W-1:0];
        end
        OFS_PARAM: begin
          // Selecting a parameter shows its stored value
          next_s.param_sel = hwdata[IDX_W-1:0];
          next_s.keypad_freq_setting = s.slot[hwdata[IDX_W-1:0]]; // RULE_13
        end
        default: begin
          for (int i = 0; i < NTERM; i++) begin
            if (s.addr == OFS_TERM_FUNCTION_VIEW_KEY + 12'(i * 4)) begin
              next_s.term_function_view_key[i] = hwdata[CODE_W-1:0];
            end
          end
        end
      endcase
    end

    // Stores: slot contents never change otherwise RULE_05 RULE_06
    if (store_dir) begin
      next_s.slot[s.param_sel] = s.keypad_freq_setting; // RULE_13
    end
    // Terminal store is refused while the drive runs RULE_10
    if (store_sel && !sel.run) begin
      next_s.slot[sel.index] = s.keypad_freq_setting; // RULE_12
      next_s.keypad_freq_setting = s.keypad_freq_setting; // RULE_12
    end

    // Target and monitor
    // Monitor idles at zero so a stopped drive never shows a speed
    next_s.target = lim_freq; // RULE_18
    if (sel.run) begin
      next_s.monitor = lim_freq; // RULE_08
    end else begin
      next_s.monitor = '0;
    end
  end

  // ==========================================================
  // State register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      s                     <= '0;
      s.st                  <= MSS_BUS_IDLE;
      s.ready               <= 1'b1;
      s.keypad_freq_setting <= RST_FREQ;
      s.max_freq_limit      <= LIMIT_RESET;
      s.freq_source_select  <= RST_SRC;
      s.term_function_view_key           <= RST_FUNCTION_VIEW_KEY;
      s.rdata               <= '0;
      s.resp                <= 1'b0;
      s.slot                <= '0;
      s.idx                 <= '0;
      s.target              <= '0;
      s.monitor             <= '0;
    end else begin
      s <= next_s;
    end
  end

  // ==========================================================
  // Outputs, all from flops
  assign hrdata              = s.rdata;
  assign hreadyout           = s.ready;
  assign hresp               = s.resp;
  assign output_freq_monitor = s.monitor;
  assign target_freq         = s.target;
  assign speed_index         = s.idx;
endmodule

/* File: verification/mss_top_assertions.sv */
// Port-level assertions of the multi-speed select block
`timescale 1ns/100ps
module mss_top_assertions import mss_pkg::*; (
  // Clock and reset
  input wire logic              sys_clk,
  input wire logic              rst,
  // Bus
  input wire logic              hsel,
  input wire logic [31:0]       haddr,
  input wire logic [1:0]        htrans,
  input wire logic              hwrite,
  input wire logic [2:0]        hsize,
  input wire logic              hready,
  input wire logic [31:0]       hwdata,
  input wire logic [31:0]       hrdata,
  input wire logic              hreadyout,
  input wire logic              hresp,
  // Pins and results
  input wire logic [NTERM-1:0]  term_in,
  input wire logic              run_cmd,
  input wire logic [FREQ_W-1:0] output_freq_monitor,
  input wire logic [FREQ_W-1:0] target_freq,
  input wire logic [IDX_W-1:0]  speed_index
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic rd_go;
  logic wr_go;
  assign rd_go = hsel && hready && htrans[1] && !hwrite;
  assign wr_go = hsel && hready && htrans[1] && hwrite;
  // ==========
  // Bus answers
  a_resp_okay: assert property (hresp == 1'b0)
    else $error("hresp not OKAY");
  a_read_wait: assert property (rd_go |=> !hreadyout ##1 hreadyout)
    else $error("read wait not one cycle");
  a_write_nowait: assert property (wr_go |=> hreadyout)
    else $error("write data phase stalled");
  a_ready_cause: assert property ($fell(hreadyout) |-> $past(rd_go))
    else $error("wait state without a read");
  a_rdata_hold: assert property ($changed(hrdata) |-> $past(rd_go, 2))
    else $error("read data moved without a read");
  // ==========
  // Monitor and index; three held run_cmd cycles for the monitor, eight quiet cycles for the index so a reset release settles first
  a_mon_stop: assert property ((!run_cmd)[*3] |=> output_freq_monitor == 16'h0000)
    else $error("monitor not zero when stopped");
  a_mon_run: assert property (run_cmd[*3] |=> output_freq_monitor == target_freq)
    else $error("monitor differs from target");
  a_idx_hold: assert property (($stable(term_in[4:1]) && htrans == 2'b00)[*8]
    |-> $stable(speed_index))
    else $error("index moved with quiet inputs");
endmodule

bind mss_top mss_top_assertions mss_top_assertions_inst (
  .sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
  .hwrite(hwrite), .hsize(hsize), .hready(hready), .hwdata(hwdata), .hrdata(hrdata),
  .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in), .run_cmd(run_cmd),
  .output_freq_monitor(output_freq_monitor), .target_freq(target_freq),
  .speed_index(speed_index));

/* File: verification/mss_switches.sv */
// Field switch model driving the selection and run terminals
`timescale 1ns/100ps
module mss_switches import mss_pkg::*; (
  // Clock
  input  wire logic             sys_clk,
  // Requests
  input  wire logic [IDX_W-1:0] speed_req,
  input  wire logic             run_req,
  // Terminal pins
  output logic      [NTERM-1:0] term_in,
  output logic                  run_cmd
);
  initial begin
    term_in = '0;
    run_cmd = 1'b0;
  end
  // ==========
  // Terminals 1..4 carry index bits from bit 0 upward
  always @(posedge sys_clk) begin
    term_in[IDX_W:1] <= speed_req;
    // Spare terminal chatters so its ignored function is exercised
    term_in[0] <= ~term_in[0];
    run_cmd <= run_req;
  end
endmodule

/* File: verification/multi_speed_select_test.sv */
// Self-checking bench of the multi-speed select block
`timescale 1ns/100ps
module multi_speed_select_test import mss_pkg::*;;
  logic              sys_clk;
  logic              rst;
  logic              hsel;
  logic              hwrite;
  logic              hreadyout;
  logic              hresp;
  logic              run_req;
  logic              run_cmd;
  logic [1:0]        htrans;
  logic [2:0]        hsize;
  logic [31:0]       haddr;
  logic [31:0]       hwdata;
  logic [31:0]       hrdata;
  logic [31:0]       rd;
  logic [NTERM-1:0]  term_in;
  logic [IDX_W-1:0]  speed_req;
  logic [IDX_W-1:0]  sidx;
  logic [FREQ_W-1:0] mon;
  logic [FREQ_W-1:0] tgt;
  int                num_errors;
  int                checks_done;

  mss_top mss_top_inst (.sys_clk(sys_clk), .rst(rst), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .term_in(term_in),
    .run_cmd(run_cmd), .output_freq_monitor(mon), .target_freq(tgt), .speed_index(sidx));
  mss_switches mss_switches_inst (.sys_clk(sys_clk), .speed_req(speed_req),
    .run_req(run_req), .term_in(term_in), .run_cmd(run_cmd));

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // ==========
  // Shared tasks
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h, seen %h", name, exp, seen);
    end
  endtask

  task automatic give_verdict();
    $display("Checks %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic wait_ready();
    int n;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    if (hreadyout !== 1'b1) begin
      num_errors++;
      give_verdict();
    end
  endtask

  task automatic xfer(input logic [11:0] a, input logic w, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h00000, a};
    hwrite <= w;
    htrans <= 2'b10;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    wait_ready();
    rd = hrdata;
  endtask

  task automatic rchk(input string name, input logic [11:0] a, input logic [31:0] exp);
    xfer(a, 1'b0, 32'h0);
    check(name, rd, exp);
  endtask

  // Partner edge, two sync edges, index edge, one more to observe
  task automatic settle(input logic [3:0] s, input logic r);
    speed_req <= s;
    run_req <= r;
    repeat (5) @(posedge sys_clk);
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    rchk("slot0", OFS_SLOT, 32'h0);
    rchk("slot15", OFS_SLOT + 12'h03C, 32'h0);
    rchk("unmapped", 12'h03C, 32'h0);
    rchk("limit", OFS_LIMIT, 32'(RST_LIMIT));
    rchk("func0", OFS_TERM_FUNCTION_VIEW_KEY, 32'(RST_FUNCTION_VIEW_KEY[0]));
  endtask

  task automatic t_direct_store();
    for (int n = 0; n < SLOTS; n++) begin
      xfer(OFS_PARAM, 1'b1, 32'(n));
      xfer(OFS_KEYPAD, 1'b1, 32'h40 + 32'(n));
      rchk("unstored", OFS_SLOT + 12'(4 * n), 32'h0);
      xfer(OFS_CTRL, 1'b1, 32'h2);
      rchk("stored", OFS_SLOT + 12'(4 * n), 32'h40 + 32'(n));
    end
  endtask

  task automatic t_select();
    for (int s = 0; s < SLOTS; s++) begin
      settle(4'(s), 1'b1);
      check("index", 32'(sidx), 32'(s));
      check("target", 32'(tgt), 32'h40 + 32'(s));
      check("monitor", 32'(mon), 32'h40 + 32'(s));
    end
  endtask

  task automatic t_stop_store();
    settle(4'h9, 1'b0);
    check("stopped", 32'(mon), 32'h0);
    rchk("view", OFS_KEYPAD, 32'h49);
    rchk("status", OFS_STATUS, 32'h90);
    xfer(OFS_CTRL, 1'b1, 32'h4);
    xfer(OFS_CTRL, 1'b1, 32'h8);
    xfer(OFS_CTRL, 1'b1, 32'h4);
    xfer(OFS_CTRL, 1'b1, 32'h4);
    xfer(OFS_CTRL, 1'b1, 32'h1);
    rchk("slot9", OFS_SLOT + 12'h024, 32'h4B);
    rchk("keypad", OFS_KEYPAD, 32'h4B);
    xfer(OFS_KEYPAD, 1'b1, 32'h77);
    rchk("nostore", OFS_SLOT + 12'h024, 32'h4B);
    settle(4'h9, 1'b1);
    rchk("monreg", OFS_MONITOR, 32'h4B);
    rchk("runstat", OFS_STATUS, 32'h91);
    xfer(OFS_CTRL, 1'b1, 32'h1);
    rchk("runstore", OFS_SLOT + 12'h024, 32'h4B);
  endtask

  task automatic t_limit();
    xfer(OFS_LIMIT, 1'b1, 32'h48);
    settle(4'hC, 1'b1);
    check("clamped", 32'(tgt), 32'h48);
    check("monclamp", 32'(mon), 32'h48);
    xfer(OFS_LIMIT, 1'b1, 32'h100);
    settle(4'hC, 1'b1);
    check("raised", 32'(tgt), 32'h4C);
    xfer(OFS_SRC, 1'b1, 32'h1);
    settle(4'hC, 1'b1);
    check("keysrc", 32'(tgt), 32'h77);
    xfer(OFS_SRC, 1'b1, 32'(SRC_MULTI));
    settle(4'hC, 1'b1);
    check("slotsrc", 32'(tgt), 32'h4C);
  endtask

  task automatic t_unassigned();
    xfer(OFS_TERM_FUNCTION_VIEW_KEY + 12'h010, 1'b1, 32'h0);
    settle(4'hC, 1'b1);
    check("nobit3", 32'(sidx), 32'h4);
    check("tgt4", 32'(tgt), 32'h44);
    xfer(OFS_TERM_FUNCTION_VIEW_KEY + 12'h010, 1'b1, 32'h5);
    settle(4'hC, 1'b1);
    check("bit3", 32'(sidx), 32'hC);
  endtask
  // ==========
  // Main sequence
  initial begin
    num_errors = 0;
    checks_done = 0;
    rst = 1'b1;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = HSIZE_WORD;
    hwdata = 32'h0;
    speed_req = 4'h0;
    run_req = 1'b0;
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    @(posedge sys_clk);
    t_reset();
    t_direct_store();
    t_select();
    t_stop_store();
    t_unassigned();
    t_limit();
    give_verdict();
  end
endmodule
